// ### ascp_consts.vh
// Constants for the serial conversion port
`ifndef ASCP_CONSTS_VH
`define ASCP_CONSTS_VH

// Frame layout
`define ASCP_RES_W        12
`define ASCP_LEAD_ZEROS   4
`define ASCP_FRAME_BITS   16
`define ASCP_CTRL_W       8
`define ASCP_CNT_W        5
`define ASCP_CNT_ZERO     5'h00
`define ASCP_CNT_FRAME    5'h10
`define ASCP_CNT_CTRL     5'h08
`define ASCP_CNT_ONE      5'h01
// Half-period figures: conversion 14.5 periods, acquisition 1.5 periods
`define ASCP_CONV_HALVES  29
`define ASCP_ACQ_HALVES   3
// Same end points as counter-width values
`define ASCP_HALF_ACQ     6'h03
`define ASCP_HALF_SMP     6'h20
// Bit positions inside the control word, and register reset values
`define ASCP_BIT_IGNORED  7
`define ASCP_BIT_ZERO     6
`define ASCP_CTRL_RST     8'h00
`define ASCP_RES_RST      12'h000
// Power-up time in microseconds and system clock rate
`define ASCP_PWRUP_US     5
`define ASCP_CLK_MHZ      10

`endif

// ### ascp_port.v
// Serial port and conversion sequencing of a 12-bit sampling converter
`timescale 1ns/10ps
`default_nettype none
`include "ascp_consts.vh"

module ascp_port (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        frame_sel_n,   // Active-low frame select pin
  input  wire        sclk,          // Serial clock pin
  input  wire        sdi,           // Serial data in pin
  input  wire [11:0] sample_data,   // Analog core result
  output reg         sdo_o,         // Serial data out value
  output wire        sdo_oe,        // Serial data out enable
  output reg  [7:0]  ctrl_word,     // Control register contents
  output reg         powered_up,    // Converter awake
  output reg         converting,    // Hold phase active
  output reg         result_valid,  // One-cycle pulse at conversion end
  output reg         wake_settled   // Power-up interval elapsed
);

  localparam integer PWRUP_CYC = `ASCP_PWRUP_US * `ASCP_CLK_MHZ;
  localparam [7:0]   PWRUP_MAX = PWRUP_CYC[7:0];

  // ----------------------------------------------------------------
  // Timing notes
  // ----------------------------------------------------------------
  // Every pin passes two flops; frame select and serial clock pass one more for the edge compare.
  // Pin events therefore act three system clocks after they happen.
  // The serial clock must stay well below the system clock rate,
  // so that each high and each low phase spans several clk cycles.
  // A serial clock phase shorter than one clk period may be lost.
  // The output bit changes a few clk cycles after a serial fall,
  // leaving the host the whole high-going half period to sample.
  // The analog result is taken once, when the frame start is seen.
  // Control bits arrive most significant first on serial rises.
  // Bits after the eighth rise are shifted nowhere and dropped.
  // Power-up timing counts in clk cycles from the wake request.

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Edge of a synchronised level: prev and now, rising or falling
  function ascp_edge;
    input prev;
    input now;
    input rising;
    begin
      ascp_edge = rising ? (~prev & now) : (prev & ~now);
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] cs_sync_r;
  reg [1:0] sclk_sync_r;
  reg [1:0] sdi_sync_r;
  reg       cs_d_r;
  reg       sclk_d_r;

  // Two flops on each pin
  always @(posedge clk) begin
    if (sys_rst) begin
      cs_sync_r   <= 2'h3;
      sclk_sync_r <= 2'h0;
      sdi_sync_r  <= 2'h0;
      cs_d_r      <= 1'h1;
      sclk_d_r    <= 1'h0;
    end else begin
      cs_sync_r   <= {cs_sync_r[0], frame_sel_n};
      sclk_sync_r <= {sclk_sync_r[0], sclk};
      sdi_sync_r  <= {sdi_sync_r[0], sdi};
      cs_d_r      <= cs_sync_r[1];
      sclk_d_r    <= sclk_sync_r[1];
    end
  end

  // Level and edges of the synchronised pins
  wire cs_low   = ~cs_sync_r[1];
  wire cs_fall  = ascp_edge(cs_d_r, cs_sync_r[1], 1'b0);
  wire cs_rise  = ascp_edge(cs_d_r, cs_sync_r[1], 1'b1);
  wire sc_rise  = ascp_edge(sclk_d_r, sclk_sync_r[1], 1'b1);
  wire sc_fall  = ascp_edge(sclk_d_r, sclk_sync_r[1], 1'b0);
  // Any serial clock edge, for the half-period count
  wire sc_any   = sc_rise | sc_fall;

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  reg [4:0]  rise_cnt_r;
  reg [4:0]  fall_cnt_r;
  reg [5:0]  half_cnt_r;
  reg [7:0]  ctrl_shift_r;
  reg [15:0] out_shift_r;
  reg [7:0]  pwr_cnt_r;
  reg        active_r;

  wire [15:0] frame_word = {{`ASCP_LEAD_ZEROS{1'b0}}, sample_data};
  // Acquisition end and full sample end, in serial half periods
  wire [5:0]  acq_end    = `ASCP_HALF_ACQ;
  wire [5:0]  smp_end    = `ASCP_HALF_SMP;

  // Output enable follows frame select only
  assign sdo_oe = active_r;

  // Sequencer clocked by sampled serial clock edges
  always @(posedge clk) begin
    if (sys_rst) begin
      rise_cnt_r   <= `ASCP_CNT_ZERO;
      fall_cnt_r   <= `ASCP_CNT_ZERO;
      half_cnt_r   <= 6'h00;
      ctrl_shift_r <= `ASCP_CTRL_RST;
      ctrl_word    <= `ASCP_CTRL_RST;
      out_shift_r  <= 16'h0000;
      sdo_o        <= 1'h0;
      active_r     <= 1'h0;
      converting   <= 1'h0;
      result_valid <= 1'h0;
    end else begin
      result_valid <= 1'h0;
      if (cs_fall) begin
        active_r    <= 1'h1;
        rise_cnt_r  <= `ASCP_CNT_ZERO;
        fall_cnt_r  <= `ASCP_CNT_ZERO;
        half_cnt_r  <= 6'h00;
        out_shift_r <= {frame_word[14:0], 1'b0};
        sdo_o       <= frame_word[15];  // Leading zero presented at frame start
      end else if (cs_rise) begin
        active_r   <= 1'h0;
        converting <= 1'h0;
        sdo_o      <= 1'h0;
      end else if (active_r) begin
        // Half-period count times acquisition and conversion
        if (sc_any && half_cnt_r != smp_end)
          half_cnt_r <= half_cnt_r + 6'h01;
        if (sc_any && half_cnt_r == acq_end - 6'h01)
          converting <= 1'h1;
        if (sc_any && half_cnt_r == smp_end - 6'h01) begin
          converting   <= 1'h0;
          result_valid <= 1'h1;
        end
        // Input capture, first eight bits only
        if (sc_rise && rise_cnt_r != `ASCP_CNT_FRAME) begin
          rise_cnt_r <= rise_cnt_r + `ASCP_CNT_ONE;
          if (rise_cnt_r < `ASCP_CNT_CTRL)
            ctrl_shift_r <= {ctrl_shift_r[6:0], sdi_sync_r[1]};
          if (rise_cnt_r == `ASCP_CNT_CTRL - `ASCP_CNT_ONE)
            ctrl_word <= {ctrl_shift_r[6:0], sdi_sync_r[1]};
        end
        // Output shift after falling edges, MSB first
        if (sc_fall && fall_cnt_r != `ASCP_CNT_FRAME) begin
          fall_cnt_r  <= fall_cnt_r + `ASCP_CNT_ONE;
          sdo_o       <= out_shift_r[15];
          out_shift_r <= {out_shift_r[14:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Power management
  // ----------------------------------------------------------------
  // Bit 7 ignored, bit 6 assumed zero; default mode sleeps with select high
  wire pm_default = (ctrl_word[1:0] == 2'h0);
  // Wake request: selected, or any mode other than the default
  wire awake_req  = cs_low | ~pm_default;

  // Awake while selected, or always outside the default mode
  // Settle count restarts on every sleep, so each wake waits again
  always @(posedge clk) begin
    if (sys_rst) begin
      powered_up   <= 1'h0;
      pwr_cnt_r    <= 8'h00;
      wake_settled <= 1'h0;
    end else begin
      powered_up <= awake_req;
      if (!awake_req) begin
        pwr_cnt_r    <= 8'h00;
        wake_settled <= 1'h0;
      end else if (pwr_cnt_r != PWRUP_MAX) begin
        pwr_cnt_r <= pwr_cnt_r + 8'h01;
      end else begin
        wake_settled <= 1'h1;
      end
    end
  end

endmodule // ascp_port
`default_nettype wire

// ### ascp_port_props.sv
// Checker for the serial conversion port
`timescale 1ns/10ps
`default_nettype none
module ascp_port_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       frame_sel_n,
  input wire logic       sclk,
  input wire logic       sdo_o,
  input wire logic       sdo_oe,
  input wire logic [7:0] ctrl_word,
  input wire logic       powered_up,
  input wire logic       result_valid
);
  // ----
  // Pin timing
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_oe_on_select: assert property ($fell(frame_sel_n) |-> ##[3:4] sdo_oe) else $error("oe late");
  a_oe_off_release: assert property ($rose(frame_sel_n) |-> ##[3:4] !sdo_oe) else $error("oe stuck");
  a_oe_idle_off: assert property (frame_sel_n [*5] |-> !sdo_oe) else $error("oe idle");
  a_sleep_default: assert property ((frame_sel_n && ctrl_word[1:0] == 2'b00) [*6] |-> !powered_up)
    else $error("awake idle");
  a_wake_in_frame: assert property (!frame_sel_n [*6] |-> powered_up) else $error("asleep");
  a_sdo_on_fall: assert property ($rose(sclk) |=> $stable(sdo_o) [*5]) else $error("sdo moved");
  a_lead_zeros: assert property ($rose(sdo_oe) |-> !sdo_o [*8]) else $error("lead bit");
  a_valid_timing: assert property (result_valid |-> $past(sclk, 4) && !$past(sclk) ##1 !result_valid)
    else $error("valid timing");
  cover property (result_valid);
  cover property ($rose(sdo_oe));
  cover property (frame_sel_n && powered_up);
endmodule // ascp_port_props
bind ascp_port ascp_port_props ascp_port_props_inst (.*);
`default_nettype wire

// ### ascp_host.sv
// Host serial port model
`timescale 1ns/10ps
`default_nettype none
module ascp_host (
  input wire logic clk,
  input wire logic sdo,
  output logic     frame_sel_n,
  output logic     sclk,
  output logic     sdi
);
  initial frame_sel_n = 1'b1;
  initial sclk = 1'b0; // Idle low between frames
  initial sdi = 1'b0;
  // One frame of sixteen clocks, word out and result in
  task automatic frame(input logic [7:0] w, output logic [15:0] rx);
    frame_sel_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      sdi = (w[7 - (i % 8)] & (i % 8 != 1)) ^ (i > 7);
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      rx = {rx[14:0], sdo};
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    frame_sel_n = 1'b1;
    sdi = 1'b0;
    repeat (60) @(negedge clk);
  endtask
endmodule // ascp_host
`default_nettype wire

// ### ascp_port_tb.sv
// Testbench for the serial conversion port
`timescale 1ns/10ps
`default_nettype none
module ascp_port_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] sample_data = 12'h000;
  logic [15:0] rx;
  wire         frame_sel_n, sclk, sdi, sdo_o, sdo_oe, powered_up;
  wire  [7:0]  ctrl_word;
  wire         converting, result_valid, wake_settled;
  int          n_valid = 0;
  logic        saw_conv = 1'b0, saw_settled = 1'b0;
  // Watch one-cycle and level outputs during each frame
  always @(posedge clk) begin
    if (result_valid === 1'b1) n_valid++;
    if (converting === 1'b1) saw_conv = 1'b1;
    if (wake_settled === 1'b1) saw_settled = 1'b1;
  end
  wire         sdo = sdo_oe ? sdo_o : 1'bz;
  int          n_mismatch = 0, checks = 0, cyc = 0;
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin
    n_mismatch++;
    final_report;
  end
  ascp_port ascp_port_inst (.clk(clk), .sys_rst(sys_rst), .frame_sel_n(frame_sel_n), .sclk(sclk), .sdi(sdi),
    .sample_data(sample_data), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ctrl_word(ctrl_word), .powered_up(powered_up),
    .converting(converting), .result_valid(result_valid), .wake_settled(wake_settled));
  ascp_host ascp_host_inst (.clk(clk), .sdo(sdo), .frame_sel_n(frame_sel_n), .sclk(sclk), .sdi(sdi));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Frame, then result, control word, power and driver state
  task automatic xfer(input logic [7:0] w, input logic [11:0] s, input logic up);
    sample_data = s;
    n_valid = 0;
    saw_conv = 1'b0;
    saw_settled = 1'b0;
    ascp_host_inst.frame(w, rx);
    chk("valid_pulses", 16'h0001, n_valid[15:0]);
    chk("converting", 16'h0001, {15'h0000, saw_conv});
    chk("settled", 16'h0001, {15'h0000, saw_settled});
    chk("result", {4'h0, s}, rx);
    chk("ctrl", {8'h00, w}, {8'h00, ctrl_word});
    chk("power_oe", {14'h0000, up, 1'b0}, {14'h0000, powered_up, sdo_oe});
  endtask
  task automatic t_reset;
    chk("reset", 16'h0000, {7'h00, ctrl_word, powered_up});
  endtask
  task automatic t_read_only;
    xfer(8'h00, 12'ha5c, 1'b0);
  endtask
  task automatic t_write_awake;
    xfer(8'h81, 12'h3e7, 1'b1);
  endtask
  task automatic t_back_default;
    xfer(8'h00, 12'hfff, 1'b0);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    t_reset;
    t_read_only;
    t_write_awake;
    t_back_default;
    final_report;
  end
endmodule // ascp_port_tb
`default_nettype wire
